// ### spmi_pkg.sv
// Purpose: Constants for the stereo PDM microphone input block.
// Assumes: System clock of 40 MHz; 16-bit register words.
// Notes:   Clock tables are indexed [high_perf][rate][ratio].
package spmi_pkg;

  localparam longint CLK_HZ = 40_000_000;
  localparam int     NCO_W  = 24;

  // Register offsets.
  localparam logic [7:0] ADDR_VOL_LEFT  = 8'h15;
  localparam logic [7:0] ADDR_VOL_RIGHT = 8'h16;
  localparam logic [7:0] ADDR_PWR_ONE   = 8'h19;
  localparam logic [7:0] ADDR_CLOCKING  = 8'h40;
  localparam logic [7:0] ADDR_PIN_FN0   = 8'h41;
  localparam logic [7:0] ADDR_STATUS    = 8'h48;

  // Field positions.
  localparam int BIT_PATH_EN   = 10;
  localparam int BIT_LEFT_EN   = 3;
  localparam int BIT_RIGHT_EN  = 2;
  localparam int BIT_VOL_UPD   = 8;
  localparam int RATE_LSB      = 0;
  localparam int RATIO_LSB     = 4;
  localparam int BIT_HIGH_PERF = 7;
  localparam int BIT_SYSTEM_CLOCK_EN = 8;
  localparam int BIT_OVERRUN   = 2;

  // Pin function codes and reset values.
  localparam logic [4:0] FN_PDM_DATA  = 5'h14;
  localparam logic [4:0] FN_PDM_CLOCK = 5'h13;
  localparam logic [4:0] RST_PIN_FN   = 5'h00;
  localparam logic [7:0] RST_VOL      = 8'hC0;
  localparam logic       RST_BIT      = 1'b0;
  localparam logic [3:0] RST_RATE     = 4'h0;
  localparam logic [2:0] RST_RATIO    = 3'h0;
  localparam logic [3:0] NUM_RATES    = 4'hB;

  // Phase increment that overflows the accumulator at the given rate.
  function automatic logic [NCO_W-1:0] nco_inc(input longint hz);
    return NCO_W'((hz * (64'sd1 <<< NCO_W) + CLK_HZ / 2) / CLK_HZ);
  endfunction

  // Frequency codes: 0 unsupported, then 1.024 .. 3.072 MHz.
  localparam longint PDM_HZ [7] = '{0, 1024000, 1411200, 1536000,
                                    2048000, 2822400, 3072000};
  localparam longint FS_HZ [11] = '{8000, 11025, 12000, 16000, 22050, 24000,
                                    32000, 44100, 48000, 88200, 96000};
  // Two overflows per clock period: one per phase.
  localparam logic [NCO_W-1:0] PDM_INC [7] = '{
    nco_inc(2*PDM_HZ[0]), nco_inc(2*PDM_HZ[1]), nco_inc(2*PDM_HZ[2]),
    nco_inc(2*PDM_HZ[3]), nco_inc(2*PDM_HZ[4]), nco_inc(2*PDM_HZ[5]),
    nco_inc(2*PDM_HZ[6])};
  localparam logic [NCO_W-1:0] FS_INC [11] = '{
    nco_inc(FS_HZ[0]), nco_inc(FS_HZ[1]), nco_inc(FS_HZ[2]), nco_inc(FS_HZ[3]),
    nco_inc(FS_HZ[4]), nco_inc(FS_HZ[5]), nco_inc(FS_HZ[6]), nco_inc(FS_HZ[7]),
    nco_inc(FS_HZ[8]), nco_inc(FS_HZ[9]), nco_inc(FS_HZ[10])};

  // Columns: ratio 256, 384, 512, 768, 1024, 1536, 3072, 6144.
  localparam logic [2:0] FREQ_TBL [2][11][8] = '{
    '{'{3'h1,3'h0,3'h1,3'h1,3'h1,3'h1,3'h1,3'h1},
      '{3'h2,3'h0,3'h2,3'h2,3'h2,3'h2,3'h2,3'h0},
      '{3'h3,3'h0,3'h3,3'h3,3'h3,3'h3,3'h3,3'h0},
      '{3'h1,3'h1,3'h1,3'h1,3'h1,3'h1,3'h1,3'h0},
      '{3'h2,3'h2,3'h2,3'h2,3'h2,3'h2,3'h0,3'h0},
      '{3'h3,3'h3,3'h3,3'h3,3'h3,3'h3,3'h0,3'h0},
      '{3'h4,3'h4,3'h4,3'h4,3'h4,3'h4,3'h0,3'h0},
      '{3'h5,3'h2,3'h5,3'h2,3'h5,3'h0,3'h0,3'h0},
      '{3'h6,3'h3,3'h6,3'h3,3'h6,3'h0,3'h0,3'h0},
      '{3'h5,3'h0,3'h5,3'h0,3'h0,3'h0,3'h0,3'h0},
      '{3'h6,3'h0,3'h6,3'h0,3'h0,3'h0,3'h0,3'h0}},
    '{'{3'h1,3'h0,3'h4,3'h0,3'h4,3'h4,3'h4,3'h4},
      '{3'h2,3'h0,3'h5,3'h0,3'h5,3'h0,3'h0,3'h0},
      '{3'h3,3'h0,3'h6,3'h0,3'h6,3'h0,3'h0,3'h0},
      '{3'h4,3'h0,3'h0,3'h4,3'h4,3'h4,3'h4,3'h0},
      '{3'h5,3'h0,3'h5,3'h0,3'h5,3'h0,3'h0,3'h0},
      '{3'h6,3'h0,3'h6,3'h0,3'h6,3'h0,3'h0,3'h0},
      '{3'h4,3'h0,3'h4,3'h0,3'h4,3'h0,3'h0,3'h0},
      '{3'h5,3'h0,3'h5,3'h0,3'h5,3'h0,3'h0,3'h0},
      '{3'h6,3'h0,3'h6,3'h0,3'h6,3'h0,3'h0,3'h0},
      '{3'h5,3'h0,3'h5,3'h0,3'h0,3'h0,3'h0,3'h0},
      '{3'h6,3'h0,3'h6,3'h0,3'h0,3'h0,3'h0,3'h0}}};

endpackage

// ### spmi_top.sv
// Purpose: PDM microphone pair capture, decimation, volume and sample FIFO.
// Assumes: Pins and register strobes are synchronous to clk.
// Notes:   Pin index 0..3 stands for general pins 2, 3, 5 and 6.
//
// Design decision made here: the address-and-strobe port.
`timescale 1ns/1ps
`default_nettype none

////////////////////////////////////////////////////////////////////////////////
// Sample FIFO with valid/ready on both sides.
module spmi_fifo #(
  parameter int WIDTH = 32,
  parameter int DEPTH = 32
) (
  input  wire logic                       clk,
  input  wire logic                       rst,
  input  wire logic                       in_valid,
  output logic                            in_ready,
  input  wire logic [WIDTH-1:0]           in_data,
  output logic                            out_valid,
  input  wire logic                       out_ready,
  output logic [WIDTH-1:0]                out_data,
  output logic [$clog2(DEPTH):0]          level
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wr_ptr;
  logic [AW-1:0]    rd_ptr;
  logic             push;
  logic             pop;

  // Full and empty come straight from the occupancy count.
  assign in_ready  = level != (AW+1)'(DEPTH);
  assign out_valid = level != '0;
  assign out_data  = mem[rd_ptr];
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;

  // Storage is written only on an accepted push.
  always_ff @(posedge clk) begin
    if (push) begin
      mem[wr_ptr] <= in_data;
    end
  end

  // Pointers wrap explicitly so a depth that is not a power of two works.
  always_ff @(posedge clk) begin
    if (rst) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      level  <= '0;
    end else begin
      if (push) begin
        wr_ptr <= (wr_ptr == AW'(DEPTH-1)) ? '0 : wr_ptr + 1'b1;
      end
      if (pop) begin
        rd_ptr <= (rd_ptr == AW'(DEPTH-1)) ? '0 : rd_ptr + 1'b1;
      end
      level <= level + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule

////////////////////////////////////////////////////////////////////////////////
// Top level of the microphone input.
module spmi_top
  import spmi_pkg::*;
#(
  parameter int SAMPLE_W   = 16,
  parameter int FIFO_DEPTH = 32
) (
  input  wire logic                clk,
  input  wire logic                rst,
  input  wire logic [7:0]          reg_addr,
  input  wire logic [15:0]         reg_wdata,
  input  wire logic                reg_wr,
  input  wire logic                reg_rd,
  output logic [15:0]              reg_rdata,
  input  wire logic [3:0]          pin_in,
  output logic [3:0]               pin_out,
  output logic [3:0]               pin_oe,
  input  wire logic [SAMPLE_W-1:0] adc_left,
  input  wire logic [SAMPLE_W-1:0] adc_right,
  input  wire logic                adc_valid,
  output logic                     rec_valid,
  input  wire logic                rec_ready,
  output logic [SAMPLE_W-1:0]      rec_left,
  output logic [SAMPLE_W-1:0]      rec_right
);
  localparam int LVL_W = $clog2(FIFO_DEPTH) + 1;

  logic                  path_en;
  logic                  left_en;
  logic                  right_en;
  logic [7:0]            vol_l_pend;
  logic [7:0]            vol_r_pend;
  logic [7:0]            vol_l;
  logic [7:0]            vol_r;
  logic [3:0]            rate_sel;
  logic [2:0]            ratio_sel;
  logic                  high_perf;
  logic                  system_clock_en;
  logic [4:0]            pin_fn [4];
  logic                  overrun;
  logic [2:0]            freq_code;
  logic                  cfg_ok;
  logic                  clk_run;
  logic [NCO_W-1:0]      pdm_acc;
  logic [NCO_W:0]        pdm_sum;
  logic [NCO_W-1:0]      fs_acc;
  logic [NCO_W:0]        fs_sum;
  logic                  phase_end;
  logic                  fs_tick;
  logic                  pdm_clk;
  logic                  data_bit;
  logic [8:0]            ones_l;
  logic [8:0]            ones_r;
  logic [8:0]            bits_n;
  logic signed [10:0]    diff_l;
  logic signed [10:0]    diff_r;
  logic                  src_valid;
  logic [SAMPLE_W-1:0]   src_l;
  logic [SAMPLE_W-1:0]   src_r;
  logic                  hold_valid;
  logic [2*SAMPLE_W-1:0] hold_data;
  logic                  fifo_in_ready;
  logic [LVL_W-1:0]      fifo_level;
  logic                  wr_vol_l;
  logic                  wr_vol_r;

  ////////////////////////////////////////////////////////////////////////////
  // Volume: 0.375 dB per code, 0xC0 is unity, 0 is mute. The gain is
  // approximated as a 16-step linear mantissa per 6 dB octave, which keeps
  // the stage to one small multiplier at the cost of about 0.5 dB error.
  function automatic logic [SAMPLE_W-1:0] vol_apply(
    input logic [SAMPLE_W-1:0] s,
    input logic [7:0]          v
  );
    logic signed [8:0]           d;
    logic signed [SAMPLE_W+9:0]  p;
    logic signed [SAMPLE_W+13:0] q;
    logic [4:0]                  amt;
    logic [SAMPLE_W-1:0]         r;
    d   = $signed({1'b0, v}) - 9'sd192;
    p   = $signed(s) * $signed({2'b01, d[3:0], 4'h0});
    amt = 5'd11 - 5'(d >>> 4);
    q   = ((SAMPLE_W+14)'(p) <<< 3) >>> amt;
    r   = q[SAMPLE_W-1:0];
    if (!(&q[SAMPLE_W+13:SAMPLE_W-1]) && (|q[SAMPLE_W+13:SAMPLE_W-1])) begin
      r = q[SAMPLE_W+13] ? {1'b1, {(SAMPLE_W-1){1'b0}}} : {1'b0, {(SAMPLE_W-1){1'b1}}};
    end
    if (v == 8'h00) begin
      r = '0;
    end
    return r;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Register writes.
  assign wr_vol_l = reg_wr && (reg_addr == ADDR_VOL_LEFT);
  assign wr_vol_r = reg_wr && (reg_addr == ADDR_VOL_RIGHT);

  // Power management word: path select and channel enables.
  always_ff @(posedge clk) begin
    if (rst) begin
      path_en  <= RST_BIT;
      left_en  <= RST_BIT;
      right_en <= RST_BIT;
    end else if (reg_wr && (reg_addr == ADDR_PWR_ONE)) begin
      path_en  <= reg_wdata[BIT_PATH_EN];
      left_en  <= reg_wdata[BIT_LEFT_EN];
      right_en <= reg_wdata[BIT_RIGHT_EN];
    end
  end

  // Clocking word; the high-performance bit resets to the low-power table.
  always_ff @(posedge clk) begin
    if (rst) begin
      rate_sel  <= RST_RATE;
      ratio_sel <= RST_RATIO;
      high_perf <= RST_BIT;
      system_clock_en <= RST_BIT;
    end else if (reg_wr && (reg_addr == ADDR_CLOCKING)) begin
      rate_sel  <= reg_wdata[RATE_LSB +: 4];
      ratio_sel <= reg_wdata[RATIO_LSB +: 3];
      high_perf <= reg_wdata[BIT_HIGH_PERF];
      system_clock_en <= reg_wdata[BIT_SYSTEM_CLOCK_EN];
    end
  end

  // Pending volumes load on write; the update bit moves both pairs to the
  // active stage at once so left and right change gain together.
  always_ff @(posedge clk) begin
    if (rst) begin
      vol_l_pend <= RST_VOL;
      vol_r_pend <= RST_VOL;
      vol_l      <= RST_VOL;
      vol_r      <= RST_VOL;
    end else if (wr_vol_l || wr_vol_r) begin
      vol_l_pend <= wr_vol_l ? reg_wdata[7:0] : vol_l_pend;
      vol_r_pend <= wr_vol_r ? reg_wdata[7:0] : vol_r_pend;
      if (reg_wdata[BIT_VOL_UPD]) begin
        vol_l <= wr_vol_l ? reg_wdata[7:0] : vol_l_pend;
        vol_r <= wr_vol_r ? reg_wdata[7:0] : vol_r_pend;
      end
    end
  end

  // One pin function select per pin.
  always_ff @(posedge clk) begin
    if (rst) begin
      pin_fn <= '{RST_PIN_FN, RST_PIN_FN, RST_PIN_FN, RST_PIN_FN};
    end else if (reg_wr && (reg_addr >= ADDR_PIN_FN0) && (reg_addr < ADDR_PIN_FN0 + 8'h04)) begin
      pin_fn[2'(reg_addr - ADDR_PIN_FN0)] <= reg_wdata[4:0];
    end
  end

  // Overrun is sticky; a new loss in the clearing cycle wins over the clear.
  always_ff @(posedge clk) begin
    if (rst) begin
      overrun <= RST_BIT;
    end else if (src_valid && hold_valid && !fifo_in_ready) begin
      overrun <= 1'b1;
    end else if (reg_wr && (reg_addr == ADDR_STATUS) && reg_wdata[BIT_OVERRUN]) begin
      overrun <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read data stand for exactly the cycle after the read strobe.
  always_ff @(posedge clk) begin
    if (rst || !reg_rd) begin
      reg_rdata <= '0;
    end else begin
      unique case (reg_addr)
        ADDR_VOL_LEFT:  reg_rdata <= {8'h00, vol_l_pend};
        ADDR_VOL_RIGHT: reg_rdata <= {8'h00, vol_r_pend};
        ADDR_PWR_ONE:   reg_rdata <= {5'h00, path_en, 6'h00, left_en, right_en, 2'h0};
        ADDR_CLOCKING:  reg_rdata <= {7'h00, system_clock_en, high_perf, ratio_sel, rate_sel};
        ADDR_PIN_FN0:   reg_rdata <= {11'h000, pin_fn[0]};
        8'h42:          reg_rdata <= {11'h000, pin_fn[1]};
        8'h43:          reg_rdata <= {11'h000, pin_fn[2]};
        8'h44:          reg_rdata <= {11'h000, pin_fn[3]};
        ADDR_STATUS:    reg_rdata <= 16'({fifo_level, overrun, cfg_ok, clk_run});
        default:        reg_rdata <= 16'h0000;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // The clock rate is looked up from rate, ratio and table select; an
  // unlisted pair gives code 0 and keeps the clock stopped.
  assign freq_code = (rate_sel < NUM_RATES) ?
                     FREQ_TBL[high_perf][rate_sel][ratio_sel] : 3'h0;
  assign cfg_ok    = freq_code != 3'h0;
  assign clk_run   = path_en && (left_en || right_en) && system_clock_en && cfg_ok;

  // Fractional dividers from the system clock: one overflow per phase of
  // the microphone clock, and one per output sample. Edges jitter by one
  // system clock period, which the microphones tolerate.
  assign pdm_sum   = {1'b0, pdm_acc} + {1'b0, PDM_INC[freq_code]};
  assign fs_sum    = {1'b0, fs_acc} + {1'b0, FS_INC[rate_sel < NUM_RATES ? rate_sel : 4'h0]};
  assign phase_end = clk_run && pdm_sum[NCO_W];
  assign fs_tick   = clk_run && fs_sum[NCO_W];

  // Accumulators and the clock itself, idle low while stopped.
  always_ff @(posedge clk) begin
    if (rst || !clk_run) begin
      pdm_acc <= '0;
      fs_acc  <= '0;
      pdm_clk <= 1'b0;
    end else begin
      pdm_acc <= pdm_sum[NCO_W-1:0];
      fs_acc  <= fs_sum[NCO_W-1:0];
      if (phase_end) begin
        pdm_clk <= !pdm_clk;
      end
    end
  end

  // Each clock-function pin drives the clock; other pins stay released.
  for (genvar i = 0; i < 4; i++) begin : g_pin
    assign pin_oe[i]  = pin_fn[i] == FN_PDM_CLOCK;
    assign pin_out[i] = (pin_fn[i] == FN_PDM_CLOCK) && pdm_clk;
  end

  // Data comes only from pins 2 or 3 (general pins 5 and 6) set to data.
  assign data_bit = (pin_fn[2] == FN_PDM_DATA) ? pin_in[2] :
                    ((pin_fn[3] == FN_PDM_DATA) && pin_in[3]);

  ////////////////////////////////////////////////////////////////////////////
  // Boxcar decimator: ones are counted per channel between sample ticks.
  // The end of a high phase holds the left bit, the end of a low phase the
  // right bit, because each microphone drives only its own phase.
  always_ff @(posedge clk) begin
    if (rst || !clk_run) begin
      ones_l <= '0;
      ones_r <= '0;
      bits_n <= '0;
    end else if (fs_tick) begin
      ones_l <= 9'(phase_end && pdm_clk && data_bit);
      ones_r <= 9'(phase_end && !pdm_clk && data_bit);
      bits_n <= 9'(phase_end && !pdm_clk);
    end else if (phase_end) begin
      if (pdm_clk) begin
        ones_l <= ones_l + 9'(data_bit);
      end else begin
        ones_r <= ones_r + 9'(data_bit);
        bits_n <= bits_n + 9'h001;
      end
    end
  end

  // Density to signed level: twice the ones minus the bit count.
  assign diff_l = $signed({1'b0, ones_l, 1'b0}) - $signed({2'b00, bits_n});
  assign diff_r = $signed({1'b0, ones_r, 1'b0}) - $signed({2'b00, bits_n});

  ////////////////////////////////////////////////////////////////////////////
  // Record input select, channel gating and the shared volume stage.
  assign src_valid = (left_en || right_en) && (path_en ? fs_tick : adc_valid);
  assign src_l = !left_en ? '0 : vol_apply(path_en ?
                 (SAMPLE_W'(diff_l) <<< (SAMPLE_W - 11)) : adc_left, vol_l);
  assign src_r = !right_en ? '0 : vol_apply(path_en ?
                 (SAMPLE_W'(diff_r) <<< (SAMPLE_W - 11)) : adc_right, vol_r);

  // One-word holding stage; a sample arriving while it is still blocked
  // by a full FIFO is dropped and flagged, since the microphones cannot wait.
  always_ff @(posedge clk) begin
    if (rst) begin
      hold_valid <= 1'b0;
      hold_data  <= '0;
    end else if (src_valid && (!hold_valid || fifo_in_ready)) begin
      hold_valid <= 1'b1;
      hold_data  <= {src_l, src_r};
    end else if (fifo_in_ready) begin
      hold_valid <= 1'b0;
    end
  end

  // Samples queue towards the record processing.
  spmi_fifo #(
    .WIDTH (2*SAMPLE_W),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .clk       (clk),
    .rst       (rst),
    .in_valid  (hold_valid),
    .in_ready  (fifo_in_ready),
    .in_data   (hold_data),
    .out_valid (rec_valid),
    .out_ready (rec_ready),
    .out_data  ({rec_left, rec_right}),
    .level     (fifo_level)
  );
endmodule

`default_nettype wire

// ### spmi_checker.sv
// Purpose: Concurrent checks on the ports of the microphone input block.
// Assumes: One clock domain with a synchronous active-high reset.
// Notes:   Bound into every instance of the top module.
`timescale 1ns/1ps
`default_nettype none
module spmi_checker
  import spmi_pkg::*;
#(
  parameter int SAMPLE_W   = 16,
  parameter int FIFO_DEPTH = 32
) (
  input wire logic                clk,
  input wire logic                rst,
  input wire logic [7:0]          reg_addr,
  input wire logic [15:0]         reg_wdata,
  input wire logic                reg_wr,
  input wire logic                reg_rd,
  input wire logic [15:0]         reg_rdata,
  input wire logic [3:0]          pin_in,
  input wire logic [3:0]          pin_out,
  input wire logic [3:0]          pin_oe,
  input wire logic [SAMPLE_W-1:0] adc_left,
  input wire logic [SAMPLE_W-1:0] adc_right,
  input wire logic                adc_valid,
  input wire logic                rec_valid,
  input wire logic                rec_ready,
  input wire logic [SAMPLE_W-1:0] rec_left,
  input wire logic [SAMPLE_W-1:0] rec_right
);
  logic [7:0] hi_cnt;

  // Length of the high phase; it saturates so a stuck clock never wraps under the bound.
  always_ff @(posedge clk) begin
    if (rst || !pin_out[0]) begin
      hi_cnt <= 8'h00;
    end else if (hi_cnt != 8'hFF) begin
      hi_cnt <= hi_cnt + 8'h01;
    end
  end

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);

  ////////////////////////////////////////////////////////////////////////////////
  // Pin and clock checks.
  property p_oe_only;
    (pin_out & ~pin_oe) == 4'h0;
  endproperty
  a_oe_only: assert property (p_oe_only) else $error("pin level without enable");
  property p_oe_cfg;
    !$stable(pin_oe) |-> $past(reg_wr) && ($past(reg_addr) >= ADDR_PIN_FN0)
                         && ($past(reg_addr) <= 8'h44);
  endproperty
  a_oe_cfg: assert property (p_oe_cfg) else $error("enable moved without write");
  property p_clk_same;
    (pin_oe[0] && pin_oe[1]) |-> pin_out[0] == pin_out[1];
  endproperty
  a_clk_same: assert property (p_clk_same) else $error("clock pins differ");
  property p_phase_max;
    hi_cnt <= 8'd21;
  endproperty
  a_phase_max: assert property (p_phase_max) else $error("high phase too long");

  ////////////////////////////////////////////////////////////////////////////////
  // Record output and register read checks.
  property p_hold;
    rec_valid && !rec_ready |=> rec_valid && $stable(rec_left) && $stable(rec_right);
  endproperty
  a_hold: assert property (p_hold) else $error("record word lost before pop");
  property p_pwr_res;
    reg_rd && reg_addr == ADDR_PWR_ONE |=> (reg_rdata & ~16'h040C) == 16'h0000;
  endproperty
  a_pwr_res: assert property (p_pwr_res) else $error("power reserved bits set");
  property p_status_res;
    reg_rd && reg_addr == ADDR_STATUS |=> reg_rdata[15:9] == 7'h00;
  endproperty
  a_status_res: assert property (p_status_res) else $error("status reserved bits set");
  property p_vol_res;
    reg_rd && reg_addr == ADDR_VOL_LEFT |=> reg_rdata[15:8] == 8'h00;
  endproperty
  a_vol_res: assert property (p_vol_res) else $error("volume reserved bits set");

  c_stall: cover property (rec_valid && !rec_ready);
  c_clock: cover property ($rose(pin_out[0]));
  c_two_pins: cover property (pin_oe[0] && pin_oe[1] && pin_out[0]);
endmodule

bind spmi_top spmi_checker #(.SAMPLE_W(SAMPLE_W), .FIFO_DEPTH(FIFO_DEPTH)) i_chk (
  .clk(clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
  .reg_rd(reg_rd), .reg_rdata(reg_rdata), .pin_in(pin_in), .pin_out(pin_out),
  .pin_oe(pin_oe), .adc_left(adc_left), .adc_right(adc_right), .adc_valid(adc_valid),
  .rec_valid(rec_valid), .rec_ready(rec_ready), .rec_left(rec_left), .rec_right(rec_right));
`default_nettype wire

// ### spmi_mic_pair.sv
// Purpose: Behavioural pair of PDM microphones sharing one data line.
// Assumes: The bench holds each microphone's bit steady.
// Notes:   With slow set, the line shows turnaround garbage in the first cycle of a phase.
`timescale 1ns/1ps
`default_nettype none
module spmi_mic_pair (
  input  wire logic clk,
  input  wire logic pdm_clk,
  input  wire logic slow,
  input  wire logic left_bit,
  input  wire logic right_bit,
  output logic      data_line
);
  logic prev_clk;

  // Remembers the clock level so the first cycle of each phase can be spotted.
  always_ff @(posedge clk) begin
    prev_clk <= pdm_clk;
  end

  // Left owns the line while the clock is high, right while low; each lets go otherwise.
  always_comb begin
    data_line = pdm_clk ? left_bit : right_bit;
    if (slow && prev_clk != pdm_clk) begin
      data_line = ~data_line;
    end
  end
endmodule
`default_nettype wire

// ### test_stereo_pdm_mic_input.sv
// Purpose: Self-checking bench for the stereo PDM microphone input.
// Assumes: 40 MHz clock; converter samples pass unchanged at 0 dB.
// Notes:   Decimated values are compared within one bit of the boxcar count.
`timescale 1ns/1ps
`default_nettype none
module test_stereo_pdm_mic_input
  import spmi_pkg::*;
;
  localparam int FIFO_N = 32;
  localparam int FULL   = (3072000 / 48000) * 32;
  logic clk, rst, reg_wr, reg_rd, adc_valid, rec_ready, rec_valid, slow, mic_l, mic_r;
  logic mic_line, rnd;
  logic [7:0]  reg_addr;
  logic [15:0] reg_wdata, reg_rdata, adc_left, adc_right, rec_left, rec_right;
  logic [3:0]  pin_junk, pin_out, pin_oe;
  logic [31:0] q [$];
  int err_total, n_checks;
  logic [15:0] ck_cfg [10] = '{16'h0100, 16'h0108, 16'h0118, 16'h0106, 16'h01A0,
                                16'h01A1, 16'h01C2, 16'h0111, 16'h0008, 16'h0128};
  int ck_hz [10] = '{1024000, 3072000, 1536000, 2048000, 2048000, 2822400, 3072000,
                     0, 0, 3072000};

  spmi_top #(.SAMPLE_W(16), .FIFO_DEPTH(FIFO_N)) i_dut (
    .clk(clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .pin_in({pin_junk[3], mic_line, pin_junk[1:0]}),
    .pin_out(pin_out), .pin_oe(pin_oe), .adc_left(adc_left), .adc_right(adc_right),
    .adc_valid(adc_valid), .rec_valid(rec_valid), .rec_ready(rec_ready),
    .rec_left(rec_left), .rec_right(rec_right));
  spmi_mic_pair i_mic (.clk(clk), .pdm_clk(pin_out[0]), .slow(slow), .left_bit(mic_l),
    .right_bit(mic_r), .data_line(mic_line));

  // Free-running system clock, 25 ns period.
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  // Unused pins, and the second data pin, carry noise.
  always @(posedge clk) pin_junk <= 4'($urandom);

  ////////////////////////////////////////////////////////////////////////////////
  task automatic stop_test();
    $display("checks %0d errors %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  task automatic check(input string what, input logic [31:0] e, input logic [31:0] g);
    n_checks++;
    if (g !== e) begin
      err_total++;
      $display("[ERR] %s expected %h seen %h", what, e, g);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rdc(input string what, input logic [7:0] a, input logic [15:0] m,
                     input logic [15:0] e);
    @(posedge clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd <= 1'b0;
    @(posedge clk);
    check(what, {16'h0000, e}, {16'h0000, reg_rdata & m});
  endtask
  // Waits, bounded, for a pop; with rnd set the consumer stalls at random.
  task automatic pop(output logic [31:0] w);
    for (int i = 0; i < 4000; i++) begin
      @(posedge clk);
      if (rec_valid === 1'b1 && rec_ready === 1'b1) begin
        w = {rec_left, rec_right};
        return;
      end
      if (rnd) rec_ready <= 1'($urandom);
    end
    err_total++;
    $display("[ERR] rec_valid wait expected 1 seen 0");
    stop_test();
  endtask
  task automatic adc_push();
    logic [15:0] l, r;
    l = 16'($urandom);
    r = 16'($urandom);
    @(posedge clk);
    adc_valid <= 1'b1;
    adc_left <= l;
    adc_right <= r;
    @(posedge clk);
    adc_valid <= 1'b0;
    if (q.size() < FIFO_N + 1) q.push_back({l, r});
  endtask
  // Cycles over four clock periods, or 0 when the clock never rises.
  task automatic meas(input int hz);
    int n, r, e;
    logic last;
    n = 0;
    r = 0;
    last = 1'b1;
    e = (hz == 0) ? 0 : 160000000 / hz;
    for (int i = 0; i < 400 && r < 5; i++) begin
      @(posedge clk);
      if (r > 0) n++;
      if (pin_out[0] === 1'b1 && !last) r++;
      last = pin_out[0];
    end
    check("pdm_clk_cycles", e, (n >= e - 2 && n <= e + 2) ? e : n);
  endtask
  function automatic logic [31:0] near(input int e, input logic [15:0] g);
    int v;
    if (^g === 1'bx) return 32'hFFFF_FFFF;
    v = $signed(g);
    return (v >= e - 64 && v <= e + 64) ? 32'(e) : 32'(v);
  endfunction
  task automatic pdm_chk(input int el, input int er);
    logic [31:0] w;
    repeat (4) pop(w);
    check("pdm_left", 32'(el), near(el, w[31:16]));
    check("pdm_right", 32'(er), near(er, w[15:0]));
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  // Main sequence.
  initial begin
    logic [31:0] w;
    {rst, reg_wr, reg_rd, adc_valid, rec_ready, slow, mic_l, mic_r, rnd} = 9'h100;
    {reg_addr, reg_wdata, adc_left, adc_right} = '0;
    void'($urandom(71));
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    rdc("vol_left", ADDR_VOL_LEFT, 16'hFFFF, {8'h00, RST_VOL});
    rdc("vol_right", ADDR_VOL_RIGHT, 16'hFFFF, {8'h00, RST_VOL});
    rdc("power_one", ADDR_PWR_ONE, 16'hFFFF, 16'h0000);
    rdc("clocking", ADDR_CLOCKING, 16'hFFFF, 16'h0000);
    rdc("pin_fn", ADDR_PIN_FN0, 16'hFFFF, 16'h0000);
    rdc("unmapped", 8'h7F, 16'hFFFF, 16'h0000);
    // Converter path through the FIFO: fill past full, then drain with stalls.
    wr(ADDR_PWR_ONE, 16'h000C);
    repeat (FIFO_N + 2) adc_push();
    rdc("status_full", ADDR_STATUS, 16'h01FC, 16'h0104);
    rnd = 1'b1;
    while (q.size() > 0) begin
      pop(w);
      check("rec_word", q.pop_front(), w);
    end
    rnd = 1'b0;
    rec_ready <= 1'b1;
    wr(ADDR_STATUS, 16'h0004);
    rdc("status_empty", ADDR_STATUS, 16'h01FC, 16'h0000);
    // Two clock pins, data on the first data-capable pin, noise on the second.
    for (int i = 0; i < 4; i++) begin
      wr(ADDR_PIN_FN0 + 8'(i), (i < 2) ? 16'(FN_PDM_CLOCK) : 16'(FN_PDM_DATA));
    end
    check("pin_oe", 32'h3, {28'h0, pin_oe});
    wr(ADDR_PWR_ONE, 16'h040C);
    for (int i = 0; i < 10; i++) begin
      wr(ADDR_CLOCKING, ck_cfg[i]);
      meas(ck_hz[i]);
      rdc("clock_running", ADDR_STATUS, 16'h0001, 16'(ck_hz[i] != 0));
    end
    wr(ADDR_PWR_ONE, 16'h000C);
    meas(0);
    // Left talks ones, right zeros, with late turnaround on the line.
    {slow, mic_l, mic_r} <= 3'b110;
    wr(ADDR_CLOCKING, 16'h0108);
    wr(ADDR_PWR_ONE, 16'h040C);
    pdm_chk(FULL, -FULL);
    wr(ADDR_PWR_ONE, 16'h0408);
    pdm_chk(FULL, 0);
    wr(ADDR_PWR_ONE, 16'h040C);
    // Left mute waits in the pending stage until the right write updates both.
    wr(ADDR_VOL_LEFT, 16'h0000);
    wr(ADDR_VOL_RIGHT, 16'h01C0);
    pdm_chk(0, -FULL);
    stop_test();
  end
endmodule
`default_nettype wire
